/* File: logic/fcs_pkg.sv */
// constants and types shared by the flash command sequencer
package fcs_pkg;
   localparam logic [1:0]  ASZ_ROM       = 2'b10;
   localparam logic [1:0]  ASZ_PROG      = 2'b01;
   localparam logic [1:0]  ASZ_RESET     = ASZ_ROM;
   localparam logic [1:0]  SZ_BYTE       = 2'b00;
   localparam logic [1:0]  SZ_HALF       = 2'b01;
   localparam logic [1:0]  SZ_WORD       = 2'b10;
   localparam logic [7:0]  CMD_RESET     = 8'hf0;
   localparam logic [7:0]  CMD_UNLOCK1   = 8'haa;
   localparam logic [7:0]  CMD_UNLOCK2   = 8'h55;
   localparam logic [7:0]  CMD_PROGRAM   = 8'ha0;
   localparam logic [7:0]  CMD_ERASE     = 8'h80;
   localparam logic [7:0]  CMD_CHIP      = 8'h10;
   localparam logic [7:0]  CMD_SECTOR    = 8'h30;
   localparam logic [11:0] ADDR_UNLOCK1  = 12'haa8;
   localparam logic [11:0] ADDR_UNLOCK2  = 12'h554;
   localparam logic [31:0] FLASH_BASE    = 32'h0000_0000;
   localparam logic [19:0] FLASH_PAGES   = 20'h00040;
   localparam int          SECT_SHIFT    = 15;
   localparam int          NUM_SECT      = 8;
   localparam int          SYS_CLK_MHZ   = 10;
   localparam int          ERASE_WIN_NS  = 40000;
   localparam logic [19:0] ERASE_WIN_CYC = 20'((ERASE_WIN_NS * SYS_CLK_MHZ + 999) / 1000);
   localparam int          ST_POLLING_DATA_FLAG       = 7;
   localparam int          ST_RUNNING_TOGGLE_FLAG       = 6;
   localparam int          ST_TIME_LIMIT_FLAG       = 5;
   localparam int          ST_ERASE_WINDOW_FLAG       = 3;
   localparam logic [2:0]  OP_PROGRAM    = 3'h1;
   localparam logic [2:0]  OP_CHIP_PRE   = 3'h2;
   localparam logic [2:0]  OP_CHIP_ERS   = 3'h3;
   localparam logic [2:0]  OP_SECT_PRE   = 3'h4;
   localparam logic [2:0]  OP_SECT_ERS   = 3'h5;
   typedef enum logic [2:0] {
      OPS_IDLE, OPS_PROG, OPS_CHIP_PRE, OPS_CHIP_ERS,
      OPS_SECT_WIN, OPS_SECT_PRE, OPS_SECT_ERS
   } fcs_op_e;
   typedef enum logic [2:0] {
      DEC_IDLE, DEC_UNL1, DEC_UNL2, DEC_PDATA, DEC_ERS1, DEC_ERS2, DEC_ERS3
   } fcs_dec_e;
endpackage : fcs_pkg

/* File: logic/fcs_cmd_if.sv */
// command write strobe towards the decoder and decoded command pulses back
`timescale 1ns/10ps
interface fcs_cmd_if;
   logic        wrStb;
   logic [11:0] lowAddr;
   logic [7:0]  lowData;
   logic        accept;
   logic        rstCmd;
   logic        progCmd;
   logic        chipCmd;
   logic        sectCmd;
   modport ctrl (output wrStb, lowAddr, lowData, accept,
                 input rstCmd, progCmd, chipCmd, sectCmd);
   modport dec  (input wrStb, lowAddr, lowData, accept,
                 output rstCmd, progCmd, chipCmd, sectCmd);
endinterface : fcs_cmd_if

/* File: logic/fcs_op_timer.sv */
// down counter giving one pulse when a loaded interval has run out
`timescale 1ns/10ps
module fcs_op_timer (
   input  wire logic        sys_clk,  // system clock
   input  wire logic        rst_n,    // async reset, low
   input  wire logic        load,     // start or restart
   input  wire logic [19:0] loadVal,  // interval in cycles
   input  wire logic        stop,     // abandon interval
   output logic             expired   // pulse at end
);
   typedef struct packed {
      logic [19:0] cnt;
      logic        run;
      logic        exp;
   } fcs_tmr_s;
   fcs_tmr_s q;
   fcs_tmr_s d;
   always_comb
   begin
      d = q;
      d.exp = 1'b0;
      if (load)
      begin
         d.cnt = loadVal;
         d.run = 1'b1;
      end
      else if (stop)
         d.run = 1'b0;
      else if (q.run)
      begin
         if (q.cnt <= 20'h00001)
         begin
            d.run = 1'b0;
            d.exp = 1'b1;
         end
         d.cnt = q.cnt - 20'h00001;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         q <= '0;
      else
         q <= d;
   assign expired = q.exp;
endmodule : fcs_op_timer

/* File: logic/fcs_cmd_decoder.sv */
// matches half-word command write sequences against the command table
`timescale 1ns/10ps
module fcs_cmd_decoder (
   input  wire logic sys_clk,  // system clock
   input  wire logic rst_n,    // async reset, low
   fcs_cmd_if.dec    cmd       // writes in, commands out
);
   typedef struct packed {
      fcs_pkg::fcs_dec_e st;
   } fcs_dec_s;
   fcs_dec_s q;
   fcs_dec_s d;
   logic     a1;
   logic     a2;
   always_comb
   begin
      d = q;
      cmd.rstCmd = 1'b0;
      cmd.progCmd = 1'b0;
      cmd.chipCmd = 1'b0;
      cmd.sectCmd = 1'b0;
      a1 = (cmd.lowAddr == fcs_pkg::ADDR_UNLOCK1);
      a2 = (cmd.lowAddr == fcs_pkg::ADDR_UNLOCK2);
      if (!cmd.accept)
         d.st = fcs_pkg::DEC_IDLE;
      else if (cmd.wrStb)
      begin
         d.st = fcs_pkg::DEC_IDLE;
         case (q.st)
            fcs_pkg::DEC_IDLE:
               if (cmd.lowData == fcs_pkg::CMD_RESET)
                  cmd.rstCmd = 1'b1;
               else if (a1 && cmd.lowData == fcs_pkg::CMD_UNLOCK1)
                  d.st = fcs_pkg::DEC_UNL1;
            fcs_pkg::DEC_UNL1:
               if (a2 && cmd.lowData == fcs_pkg::CMD_UNLOCK2)
                  d.st = fcs_pkg::DEC_UNL2;
            fcs_pkg::DEC_UNL2:
               if (a1 && cmd.lowData == fcs_pkg::CMD_RESET)
                  cmd.rstCmd = 1'b1;
               else if (a1 && cmd.lowData == fcs_pkg::CMD_PROGRAM)
                  d.st = fcs_pkg::DEC_PDATA;
               else if (a1 && cmd.lowData == fcs_pkg::CMD_ERASE)
                  d.st = fcs_pkg::DEC_ERS1;
            fcs_pkg::DEC_PDATA:
               cmd.progCmd = 1'b1;
            fcs_pkg::DEC_ERS1:
               if (a1 && cmd.lowData == fcs_pkg::CMD_UNLOCK1)
                  d.st = fcs_pkg::DEC_ERS2;
            fcs_pkg::DEC_ERS2:
               if (a2 && cmd.lowData == fcs_pkg::CMD_UNLOCK2)
                  d.st = fcs_pkg::DEC_ERS3;
            fcs_pkg::DEC_ERS3:
               if (a1 && cmd.lowData == fcs_pkg::CMD_CHIP)
                  cmd.chipCmd = 1'b1;
               else if (cmd.lowData == fcs_pkg::CMD_SECTOR)
                  cmd.sectCmd = 1'b1;
            default:
               d.st = fcs_pkg::DEC_IDLE;
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
         q <= '{st: fcs_pkg::DEC_IDLE};
      else
         q <= d;
endmodule : fcs_cmd_decoder

/* File: logic/fcs_sequencer.sv */
// flash access mode, command sequencing and embedded operation control
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module fcs_sequencer #(
   parameter int unsigned OP_LIMIT_CYC = 200000  // rated time of one phase
) (
   input  wire logic        sys_clk,            // system clock, 10 MHz
   input  wire logic        rst_n,              // async reset, low
   input  wire logic        aszWrEn,            // write access size field
   input  wire logic [1:0]  aszWrData,          // new access size value
   output logic [1:0]       accessSizeSel,      // current access size field
   output logic             fetchEnable,        // code fetch from flash allowed
   input  wire logic        busReq,             // access request pulse
   input  wire logic        busWrite,           // 1 write, 0 read
   input  wire logic [1:0]  busSize,            // byte, half or word
   input  wire logic [31:0] busAddr,            // byte address
   input  wire logic [15:0] busWdata,           // half-word write data
   output logic             busAck,             // answer pulse
   output logic             busErr,             // access refused
   output logic [31:0]      busRdata,           // read data
   output logic [31:0]      arrRdAddr,          // array read word address
   input  wire logic [31:0] arrRdData,          // array read data
   output logic             arrOpStart,         // array phase start pulse
   output logic [2:0]       arrOpCode,          // array phase kind
   output logic [31:0]      arrOpAddr,          // program or sector address
   output logic [15:0]      arrOpData,          // program value
   output logic             arrOpAbort,         // abandon array phase
   input  wire logic        arrOpDone,          // array phase finished
   output logic             readyFlag,          // no operation running
   output logic             timeLimitFlag,      // rated time exceeded
   output logic             eraseWindowFlag,    // sector window has closed
   output logic             runningToggleFlag,  // toggle bit next read returns
   output logic             pollingDataFlag     // polling bit now
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [1:0]              access_size_sel;
      fcs_pkg::fcs_op_e        st;
      logic                    issued;
      logic                    time_limit_flag;
      logic                    tog;
      logic [fcs_pkg::NUM_SECT-1:0] sectMap;
      logic [2:0]              curSect;
      logic [31:0]             progAddr;
      logic [15:0]             progData;
      logic                    pend;
      logic                    pWr;
      logic [1:0]              pSz;
      logic                    pHi;
      logic                    ack;
      logic                    err;
      logic [31:0]             rdata;
      logic [31:0]             rdAddr;
      logic                    opStart;
      logic [2:0]              opCode;
      logic [31:0]             opAddr;
      logic                    abort;
   } fcs_seq_s;

   fcs_seq_s q;
   fcs_seq_s d;

   fcs_cmd_if cmd ();

   logic       progMode;
   logic       running;
   logic       take;
   logic       cmdWr;
   logic       winExp;
   logic       limExp;
   logic       winLoad;
   logic       limLoad;
   logic [7:0] statusByte;
   logic       polling_data_flag;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic in_flash(input logic [31:0] a);
      logic [19:0] page;
      page = a[31:12] - fcs_pkg::FLASH_BASE[31:12];
      return page < fcs_pkg::FLASH_PAGES;
   endfunction : in_flash

   function automatic logic [2:0] sect_of(input logic [31:0] a);
      logic [31:0] off;
      off = a - fcs_pkg::FLASH_BASE;
      return off[fcs_pkg::SECT_SHIFT +: 3];
   endfunction : sect_of

   function automatic logic [2:0] lowest(input logic [fcs_pkg::NUM_SECT-1:0] m);
      logic [2:0] r;
      r = 3'h0;
      for (int i = fcs_pkg::NUM_SECT - 1; i >= 0; i--)
         if (m[i])
            r = 3'(i);
      return r;
   endfunction : lowest

   function automatic logic [31:0] sect_base(input logic [2:0] s);
      return fcs_pkg::FLASH_BASE + (32'(s) << fcs_pkg::SECT_SHIFT);
   endfunction : sect_base

   ////////////////////////////////////////////////////////////////////////////
   assign progMode = (q.access_size_sel == fcs_pkg::ASZ_PROG);
   assign running  = (q.st != fcs_pkg::OPS_IDLE);
   assign take     = busReq && !q.pend;
   // commands only as in-range half-word writes in programming mode
   assign cmdWr    = take && busWrite && progMode && busSize == fcs_pkg::SZ_HALF
                     && in_flash(busAddr);

   assign cmd.wrStb   = cmdWr;
   assign cmd.lowAddr = busAddr[11:0];
   assign cmd.lowData = busWdata[7:0];
   // the decoder only listens when a new command can be started or an
   // overrun operation is waiting for its read/reset
   assign cmd.accept  = progMode && (!running || q.time_limit_flag);

   fcs_cmd_decoder u_dec (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .cmd     (cmd)
   );

   fcs_op_timer u_win (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (winLoad),
      .loadVal (fcs_pkg::ERASE_WIN_CYC),
      .stop    (q.abort),
      .expired (winExp)
   );

   fcs_op_timer u_lim (
      .sys_clk (sys_clk),
      .rst_n   (rst_n),
      .load    (limLoad),
      .loadVal (20'(OP_LIMIT_CYC)),
      .stop    (q.abort || !q.issued),
      .expired (limExp)
   );

   assign limLoad = q.opStart;

   always_comb
   begin
      case (q.st)
         fcs_pkg::OPS_PROG:     polling_data_flag = ~q.progData[7];
         fcs_pkg::OPS_SECT_WIN: polling_data_flag = 1'b1;
         default:               polling_data_flag = 1'b0;
      endcase
      statusByte = 8'h00;
      statusByte[fcs_pkg::ST_POLLING_DATA_FLAG] = polling_data_flag;
      statusByte[fcs_pkg::ST_RUNNING_TOGGLE_FLAG] = q.tog;
      statusByte[fcs_pkg::ST_TIME_LIMIT_FLAG] = q.time_limit_flag;
      statusByte[fcs_pkg::ST_ERASE_WINDOW_FLAG] = q.st != fcs_pkg::OPS_SECT_WIN
                                     && q.st != fcs_pkg::OPS_PROG;
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      d = q;
      d.ack = 1'b0;
      d.err = 1'b0;
      d.opStart = 1'b0;
      d.abort = 1'b0;
      winLoad = 1'b0;

      if (aszWrEn)
         d.access_size_sel = aszWrData;

      // bus side: take, then answer two edges later
      if (take)
      begin
         d.pend = 1'b1;
         d.pWr = busWrite;
         d.pSz = busSize;
         d.pHi = busAddr[1];
         d.rdAddr = {busAddr[31:2], 2'b00};
      end
      if (q.pend)
      begin
         d.pend = 1'b0;
         d.ack = 1'b1;
         if (!q.pWr)
         begin
            if (progMode && q.pSz == fcs_pkg::SZ_WORD)
            begin
               d.err = 1'b1;
               d.rdata = 32'h0000_0000;
            end
            else if (progMode && running)
            begin
               d.rdata = {24'h000000, statusByte};
               d.tog = ~q.tog;
            end
            else if (progMode)
               d.rdata = {16'h0000, q.pHi ? arrRdData[31:16] : arrRdData[15:0]};
            else
               d.rdata = arrRdData;
         end
      end

      // embedded operation sequencing
      case (q.st)
         fcs_pkg::OPS_IDLE:
         begin
            d.issued = 1'b0;
            d.time_limit_flag = 1'b0;
            d.tog = 1'b0;
            if (cmd.progCmd)
            begin
               d.progAddr = busAddr;
               d.progData = busWdata;
               d.st = fcs_pkg::OPS_PROG;
            end
            else if (cmd.chipCmd)
               d.st = fcs_pkg::OPS_CHIP_PRE;
            else if (cmd.sectCmd)
            begin
               d.sectMap = '0;
               d.sectMap[sect_of(busAddr)] = 1'b1;
               winLoad = 1'b1;
               d.st = fcs_pkg::OPS_SECT_WIN;
            end
         end
         fcs_pkg::OPS_SECT_WIN:
         begin
            // later codes extend the set and restart the window
            if (cmdWr && busWdata[7:0] == fcs_pkg::CMD_SECTOR)
            begin
               d.sectMap[sect_of(busAddr)] = 1'b1;
               winLoad = 1'b1;
            end
            else if (winExp)
            begin
               d.curSect = lowest(q.sectMap);
               d.st = fcs_pkg::OPS_SECT_PRE;
            end
         end
         default:
         begin
            if (!q.issued)
            begin
               d.issued = 1'b1;
               d.opStart = 1'b1;
               case (q.st)
                  fcs_pkg::OPS_PROG:
                  begin
                     d.opCode = fcs_pkg::OP_PROGRAM;
                     d.opAddr = q.progAddr;
                  end
                  fcs_pkg::OPS_CHIP_PRE:
                  begin
                     d.opCode = fcs_pkg::OP_CHIP_PRE;
                     d.opAddr = fcs_pkg::FLASH_BASE;
                  end
                  fcs_pkg::OPS_CHIP_ERS:
                  begin
                     d.opCode = fcs_pkg::OP_CHIP_ERS;
                     d.opAddr = fcs_pkg::FLASH_BASE;
                  end
                  fcs_pkg::OPS_SECT_PRE:
                  begin
                     d.opCode = fcs_pkg::OP_SECT_PRE;
                     d.opAddr = sect_base(q.curSect);
                  end
                  default:
                  begin
                     d.opCode = fcs_pkg::OP_SECT_ERS;
                     d.opAddr = sect_base(q.curSect);
                  end
               endcase
            end
            else if (arrOpDone && !q.time_limit_flag)
            begin
               d.issued = 1'b0;
               case (q.st)
                  fcs_pkg::OPS_CHIP_PRE: d.st = fcs_pkg::OPS_CHIP_ERS;
                  fcs_pkg::OPS_SECT_PRE: d.st = fcs_pkg::OPS_SECT_ERS;
                  fcs_pkg::OPS_SECT_ERS:
                  begin
                     d.sectMap[q.curSect] = 1'b0;
                     if ((q.sectMap & ~(8'h01 << q.curSect)) == '0)
                        d.st = fcs_pkg::OPS_IDLE;
                     else
                     begin
                        d.curSect = lowest(q.sectMap & ~(8'h01 << q.curSect));
                        d.st = fcs_pkg::OPS_SECT_PRE;
                     end
                  end
                  default:               d.st = fcs_pkg::OPS_IDLE;
               endcase
            end
            if (limExp)
               d.time_limit_flag = 1'b1;
         end
      endcase

      // overrun operation is ended only by read/reset
      if (running && q.time_limit_flag && cmd.rstCmd)
      begin
         d.abort = 1'b1;
         d.st = fcs_pkg::OPS_IDLE;
         d.issued = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n)
      if (!rst_n)
      begin
         q <= '0;
         q.access_size_sel <= fcs_pkg::ASZ_RESET;
         q.st <= fcs_pkg::OPS_IDLE;
      end
      else
         q <= d;

   ////////////////////////////////////////////////////////////////////////////
   assign accessSizeSel     = q.access_size_sel;
   assign fetchEnable       = (q.access_size_sel == fcs_pkg::ASZ_ROM);
   assign busAck            = q.ack;
   assign busErr            = q.err;
   assign busRdata          = q.rdata;
   assign arrRdAddr         = q.rdAddr;
   assign arrOpStart        = q.opStart;
   assign arrOpCode         = q.opCode;
   assign arrOpAddr         = q.opAddr;
   assign arrOpData         = q.progData;
   assign arrOpAbort        = q.abort;
   assign readyFlag         = (q.st == fcs_pkg::OPS_IDLE);
   assign timeLimitFlag     = q.time_limit_flag;
   assign eraseWindowFlag   = q.st != fcs_pkg::OPS_SECT_WIN && q.st != fcs_pkg::OPS_PROG
                              && q.st != fcs_pkg::OPS_IDLE;
   assign runningToggleFlag = q.tog;
   assign pollingDataFlag   = polling_data_flag;

endmodule : fcs_sequencer

/* File: dv/fcs_props.sv */
// concurrent checks on the sequencer top ports
`timescale 1ns/10ps
module fcs_props (
   input wire logic        sys_clk,        // clock
   input wire logic        rst_n,          // reset, low
   input wire logic        busReq,         // request
   input wire logic        busWrite,       // write
   input wire logic [1:0]  busSize,        // size
   input wire logic        busAck,         // answer
   input wire logic        busErr,         // refused
   input wire logic [31:0] busRdata,       // read data
   input wire logic [1:0]  accessSizeSel,  // mode
   input wire logic        fetchEnable,    // fetch allowed
   input wire logic        arrOpStart,     // phase start
   input wire logic        arrOpAbort,     // abort
   input wire logic        readyFlag       // idle
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   ////////////////////////////////////////////////////////////////////////////////
   sequence s_req; busReq; endsequence
   sequence s_ans; ##2 busAck; endsequence
   property p_ack; s_req |-> s_ans; endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_fetch; fetchEnable == (accessSizeSel == fcs_pkg::ASZ_ROM); endproperty
   a_fetch: assert property (p_fetch) else $error("fetch enable wrong");
   property p_rom; accessSizeSel == fcs_pkg::ASZ_ROM && readyFlag |-> ##2 !arrOpStart; endproperty
   a_rom: assert property (p_rom) else $error("operation in rom mode");
   property p_word;
      busReq && !busWrite && busSize == fcs_pkg::SZ_WORD && accessSizeSel == fcs_pkg::ASZ_PROG
      |-> ##2 busErr && busRdata == 32'h0;
   endproperty
   a_word: assert property (p_word) else $error("word read taken");
   property p_wrOk; busReq && busWrite |-> ##2 !busErr; endproperty
   a_wrOk: assert property (p_wrOk) else $error("write refused");
   property p_half;
      busReq && !busWrite && busSize == fcs_pkg::SZ_HALF && accessSizeSel == fcs_pkg::ASZ_PROG
      && readyFlag |-> ##2 busRdata[31:16] == 16'h0;
   endproperty
   a_half: assert property (p_half) else $error("half read too wide");
   property p_rst; $rose(rst_n) |-> accessSizeSel == fcs_pkg::ASZ_ROM; endproperty
   a_rst: assert property (p_rst) else $error("mode not rom after reset");
   property p_busy; arrOpStart |-> !readyFlag; endproperty
   a_busy: assert property (p_busy) else $error("ready while running");
   property p_abort; arrOpAbort |-> ##[0:2] readyFlag; endproperty
   a_abort: assert property (p_abort) else $error("abort left busy");
endmodule : fcs_props
bind fcs_sequencer fcs_props fcs_props_inst (.*);

/* File: dv/fcs_array_model.sv */
// behavioural flash array: fixed fill pattern, phases done after a set delay
`timescale 1ns/10ps
module fcs_array_model (
   input  wire logic        sys_clk,     // clock
   input  wire logic        rst_n,       // reset, low
   input  wire logic [31:0] arrRdAddr,   // read word address
   output logic [31:0]      arrRdData,   // read word
   input  wire logic        arrOpStart,  // phase start
   input  wire logic        arrOpAbort,  // abandon phase
   input  wire logic [7:0]  opDelay,     // cycles to done, 0 never
   output logic             arrOpDone    // phase done
);
   logic [7:0] cnt_q;
   // arbitrary pattern, differs per word
   assign arrRdData = {arrRdAddr[31:2], 2'b00} ^ 32'h5a5a_a5a5;
   ////////////////////////////////////////////////////////////////////////////////
   // delay 0 models a locked array that never finishes
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_q     <= 8'h0;
         arrOpDone <= 1'b0;
      end
      else
      begin
         arrOpDone <= (cnt_q == 8'h1);
         if (arrOpStart) cnt_q <= opDelay;
         else if (arrOpAbort) cnt_q <= 8'h0;
         else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
      end
   end
endmodule : fcs_array_model

/* File: dv/flash_command_sequencer_tb.sv */
// self-checking bench for the flash command sequencer
`timescale 1ns/10ps
module flash_command_sequencer_tb;
   localparam int LIM = 50;
   logic sys_clk = 0, rst_n = 0, aszWrEn = 0, busReq = 0, busWrite = 0;
   logic [1:0] aszWrData = 2'h0, busSize = 2'h0, accessSizeSel;
   logic [31:0] busAddr = 32'h0, busRdata, arrRdAddr, arrRdData, arrOpAddr, t, a, d;
   logic [15:0] busWdata = 16'h0, arrOpData;
   logic [7:0] opDelay = 8'h1e;
   logic [2:0] arrOpCode;
   logic fetchEnable, busAck, busErr, arrOpStart, arrOpAbort, arrOpDone, readyFlag;
   logic timeLimitFlag, eraseWindowFlag, runningToggleFlag, pollingDataFlag;
   logic [33:0] bq[$], e;
   logic [34:0] oq[$];
   int mismatches = 0, num_checks = 0, cyc = 0;
   logic [31:0] seed = 32'h9184c6b0;
   logic [11:0] pa[5] = '{12'haa8, 12'h554, 12'haa8, 12'haa8, 12'h554};
   logic [7:0] pd[5] = '{8'haa, 8'h55, 8'h80, 8'haa, 8'h55};
   fcs_sequencer #(.OP_LIMIT_CYC(LIM)) fcs_sequencer_inst (.*);
   fcs_array_model fcs_array_model_inst (.*);
   initial forever #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] pat(input logic [31:0] x);
      return {x[31:2], 2'b00} ^ 32'h5a5a_a5a5;
   endfunction : pat
   task automatic chk(input logic [34:0] seen, input logic [34:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : end_sim
   task automatic acc(input logic w, input logic [1:0] sz, input logic [31:0] x,
                      input logic [15:0] v, input logic [33:0] ex);
      bq.push_back(ex);
      @(posedge sys_clk);
      busReq <= 1'b1;
      busWrite <= w;
      busSize <= sz;
      busAddr <= x;
      busWdata <= v;
      @(posedge sys_clk);
      busReq <= 1'b0;
      @(posedge sys_clk);
   endtask : acc
   // random page and upper data byte: only low bits may matter
   task automatic wr(input logic [11:0] x, input logic [7:0] v);
      logic [31:0] r;
      r = rnd();
      acc(1'b1, fcs_pkg::SZ_HALF, fcs_pkg::FLASH_BASE | {14'h0, r[5:0], x}, {r[15:8], v}, 34'h0);
   endtask : wr
   task automatic pre(input int n, input logic [7:0] third);
      for (int i = 0; i < n; i++) wr(pa[i], i == 2 ? third : pd[i]);
   endtask : pre
   task automatic waitReady;
      for (int i = 0; i < 3000 && readyFlag !== 1'b1; i++) @(posedge sys_clk);
      chk(readyFlag, 1'b1);
   endtask : waitReady
   ////////////////////////////////////////////////////////////////////////////////
   always @(negedge sys_clk)
   begin
      if (busAck === 1'b1)
      begin
         e = bq.pop_front();
         chk(busErr, e[32]);
         if (e[33]) chk(busRdata, e[31:0]);
      end
      if (arrOpStart === 1'b1) chk({arrOpCode, arrOpAddr}, oq.pop_front());
   end
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         end_sim();
      end
   end
   initial
   begin
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      @(posedge sys_clk);
      chk({accessSizeSel, fetchEnable, readyFlag}, {fcs_pkg::ASZ_ROM, 2'b11});
      acc(1'b0, fcs_pkg::SZ_WORD, 32'h1234, 16'h0, {2'b10, pat(32'h1234)});
      pre(3, fcs_pkg::CMD_PROGRAM);
      wr(12'h100, 8'h00);
      chk(readyFlag, 1'b1);
      $display("test rom done");
      @(posedge sys_clk);
      aszWrEn <= 1'b1;
      aszWrData <= fcs_pkg::ASZ_PROG;
      @(posedge sys_clk);
      aszWrEn <= 1'b0;
      acc(1'b0, fcs_pkg::SZ_WORD, 32'h10, 16'h0, {2'b11, 32'h0});
      t = pat(32'h12);
      acc(1'b0, fcs_pkg::SZ_HALF, 32'h12, 16'h0, {2'b10, 16'h0, t[31:16]});
      for (int k = 0; k < 2; k++)
      begin
         t = rnd();
         d = rnd();
         a = fcs_pkg::FLASH_BASE | {14'h0, t[17:1], 1'b0};
         pre(3, fcs_pkg::CMD_PROGRAM);
         oq.push_back({fcs_pkg::OP_PROGRAM, a});
         acc(1'b1, fcs_pkg::SZ_HALF, a, d[15:0], 34'h0);
         for (int j = 0; j < 2; j++)
            acc(1'b0, fcs_pkg::SZ_HALF, a, 16'h0, {2'b10, 24'h0, ~d[7], j[0], 6'h0});
         waitReady;
      end
      $display("test program done");
      pre(1, 8'h0);
      wr(12'h555, fcs_pkg::CMD_UNLOCK2);
      wr(fcs_pkg::ADDR_UNLOCK1, fcs_pkg::CMD_PROGRAM);
      wr(12'h100, 8'h12);
      for (int i = 0; i < 4; i++)
         acc(1'b1, fcs_pkg::SZ_HALF, {12'h0, 8'h40, i < 3 ? pa[i] : 12'h100},
             {8'h0, i == 2 ? fcs_pkg::CMD_PROGRAM : pd[i]}, 34'h0);
      chk(readyFlag, 1'b1);
      $display("test mismatch done");
      pre(5, fcs_pkg::CMD_ERASE);
      oq.push_back({fcs_pkg::OP_CHIP_PRE, fcs_pkg::FLASH_BASE});
      oq.push_back({fcs_pkg::OP_CHIP_ERS, fcs_pkg::FLASH_BASE});
      wr(fcs_pkg::ADDR_UNLOCK1, fcs_pkg::CMD_CHIP);
      waitReady;
      pre(5, fcs_pkg::CMD_ERASE);
      for (int i = 2; i < 5; i += 2) // lowest sector first
      begin
         oq.push_back({fcs_pkg::OP_SECT_PRE, 32'(i) << fcs_pkg::SECT_SHIFT});
         oq.push_back({fcs_pkg::OP_SECT_ERS, 32'(i) << fcs_pkg::SECT_SHIFT});
      end
      acc(1'b1, fcs_pkg::SZ_HALF, (32'h4 << fcs_pkg::SECT_SHIFT) + 32'h1234, 16'h7730, 34'h0);
      acc(1'b1, fcs_pkg::SZ_HALF, (32'h2 << fcs_pkg::SECT_SHIFT) + 32'h0ff0, 16'h1130, 34'h0);
      repeat (100) @(posedge sys_clk);
      chk(eraseWindowFlag, 1'b0);
      waitReady;
      $display("test erase done");
      opDelay <= 8'h0;
      for (int k = 0; k < 2; k++)
      begin
         pre(3, fcs_pkg::CMD_PROGRAM);
         oq.push_back({fcs_pkg::OP_PROGRAM, 32'h2000});
         acc(1'b1, fcs_pkg::SZ_HALF, 32'h2000, 16'h5a7f, 34'h0);
         repeat (LIM + 10) @(posedge sys_clk);
         chk({timeLimitFlag, pollingDataFlag, runningToggleFlag, arrOpData},
             19'h65a7f);
         pre(2 * k, 8'h0);
         wr(k ? fcs_pkg::ADDR_UNLOCK1 : 12'h0, fcs_pkg::CMD_RESET);
         waitReady;
         t = pat(32'h40);
         acc(1'b0, fcs_pkg::SZ_HALF, 32'h40, 16'h0, {2'b10, 16'h0, t[15:0]});
      end
      $display("test abort done");
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      chk(accessSizeSel, fcs_pkg::ASZ_ROM);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      $display("test reset done");
      end_sim();
   end
endmodule : flash_command_sequencer_tb
